// *** verilog/iec_pkg.sv ***
`default_nettype none
package iec_pkg;
  // Channel count and word width
  localparam int NUM_IN = 8;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 12;
  // Configure identifiers: enable 100..107, edge 110..117
  localparam logic [7:0] ENABLE_ID_BASE = 8'h64;
  localparam logic [7:0] EDGE_ID_BASE = 8'h6E;
  // Enable codes
  localparam logic [15:0] CODE_DIRECT = 16'h0000;
  localparam logic [15:0] CODE_DISABLE = 16'h0001;
  localparam logic [15:0] CODE_DOWN = 16'h0002;
  localparam logic [15:0] CODE_UP = 16'h0003;
  // Edge codes
  localparam logic [15:0] CODE_RISE = 16'h0000;
  localparam logic [15:0] CODE_FALL = 16'h0001;
  // Interrupt task of input 0; input n starts task 140 + n
  localparam logic [7:0] TASK_BASE = 8'h8C;
  // Auxiliary word addresses, setpoints and present-value copies
  localparam logic [ADDR_W-1:0] SP_ADDR [NUM_IN] = '{
    12'h214, 12'h215, 12'h216, 12'h217, 12'h220, 12'h221, 12'h222, 12'h223};
  localparam logic [ADDR_W-1:0] PV_ADDR [NUM_IN] = '{
    12'h218, 12'h219, 12'h21A, 12'h21B, 12'h224, 12'h225, 12'h226, 12'h227};
  // Reset values
  localparam logic [WORD_W-1:0] PV_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] RDATA_RESET = 16'h0000;
  localparam logic [2:0] SYNC_RESET = 3'h0;
  // Input modes
  typedef enum logic [3:0] {
    IEC_MODE_DIRECT = 4'b0001,
    IEC_MODE_OFF = 4'b0010,
    IEC_MODE_DOWN = 4'b0100,
    IEC_MODE_UP = 4'b1000
  } iec_mode_type;
  // Configure operation
  typedef struct packed {
    logic valid;
    logic [7:0] ident;
    logic [WORD_W-1:0] code;
  } iec_cfg_type;
  // Auxiliary word access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } iec_aux_req_type;
  // Direct value read operation
  typedef struct packed {
    logic valid;
    logic [2:0] index;
  } iec_dread_type;
endpackage
`default_nettype wire

// *** verilog/iec_edge_irq_counter.sv ***
`timescale 1ns/1ps
`default_nettype none
module iec_edge_irq_counter (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [iec_pkg::NUM_IN-1:0] irq_pins,
  input wire logic [iec_pkg::NUM_IN-1:0] edge_default,
  input wire logic op_start,
  input wire logic cycle_refresh,
  input wire iec_pkg::iec_cfg_type interrupt_configure_op,
  input wire iec_pkg::iec_aux_req_type aux_req,
  input wire iec_pkg::iec_dread_type direct_value_read_op,
  output logic [iec_pkg::WORD_W-1:0] aux_rdata_ff,
  output logic aux_rvalid_ff,
  output logic [iec_pkg::WORD_W-1:0] dread_value_ff,
  output logic dread_done_ff,
  output logic [iec_pkg::NUM_IN-1:0] task_start_ff,
  output logic [7:0] task_num_ff
);
  import iec_pkg::*;

  // Each input is one slice of the generate loop below. The slices share only
  // the configure and word buses and the op_start and cycle_refresh strobes,
  // so no two of them ever drive the same state.
  // Settings of a slice change only on its own strobes; op_start clears the counters of all slices.
  // Task pulses and read answers are gathered after the loop.

  // Three-stage input synchroniser per pin
  logic [2:0] sync_ff [NUM_IN];
  // Debounced level once stages two and three agree
  logic level_ff [NUM_IN];
  // Edge setting and whether software has written it
  logic edge_fall_ff [NUM_IN];
  logic edge_written_ff [NUM_IN];
  // Operating mode per input
  iec_mode_type mode_ff [NUM_IN];
  // Live counter present value
  logic [WORD_W-1:0] count_present_value_ff [NUM_IN];
  // Auxiliary copy of the present value
  logic [WORD_W-1:0] aux_pv_ff [NUM_IN];
  // Setpoint words, deliberately without reset
  logic [WORD_W-1:0] count_setpoint_ff [NUM_IN];
  // Combinational per-input results
  logic [WORD_W-1:0] nxt_pv [NUM_IN];
  logic task_hit [NUM_IN];
  logic act_edge [NUM_IN];

  // Slice index; one slice per input pin
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_in
      // Synchroniser status of this pin
      logic stable;
      logic changed;
      // Edge that is actually in force
      logic sel_fall;
      // Configure strobes aimed at this slice
      logic en_wr;
      logic edge_wr;
      // Word writes aimed at this slice
      logic pv_wr;
      logic sp_wr;

      // Pin crosses in through three flops; stage one feeds only stage two
      // Stage one may go metastable, so nothing else may look at it
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          sync_ff[gi] <= SYNC_RESET;
        end else begin
          sync_ff[gi] <= {sync_ff[gi][1:0], irq_pins[gi]};
        end
      end

      // A change counts only when stages two and three agree
      assign stable = (sync_ff[gi][1] == sync_ff[gi][2]);
      assign changed = stable && (sync_ff[gi][2] != level_ff[gi]);

      // Level resets low like the synchroniser, so reset makes no false edge
      // Limitation: a pulse shorter than about two clocks may be missed
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          level_ff[gi] <= 1'b0;
        end else if (changed) begin
          level_ff[gi] <= sync_ff[gi][2];
        end
      end

      // Decodes of the configure operation and word writes
      // Identifiers outside this slice's two match nothing and are dropped
      assign en_wr = interrupt_configure_op.valid &&
        (interrupt_configure_op.ident == ENABLE_ID_BASE + 8'(gi));
      assign edge_wr = interrupt_configure_op.valid &&
        (interrupt_configure_op.ident == EDGE_ID_BASE + 8'(gi));
      assign pv_wr = aux_req.wr && (aux_req.addr == PV_ADDR[gi]);
      assign sp_wr = aux_req.wr && (aux_req.addr == SP_ADDR[gi]);

      // Edge setting is held until rewritten; unknown codes are ignored
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          edge_fall_ff[gi] <= 1'b0;
          edge_written_ff[gi] <= 1'b0;
        end else if (edge_wr) begin
          if (interrupt_configure_op.code == CODE_RISE) begin
            edge_fall_ff[gi] <= 1'b0;
            edge_written_ff[gi] <= 1'b1;
          end else if (interrupt_configure_op.code == CODE_FALL) begin
            edge_fall_ff[gi] <= 1'b1;
            edge_written_ff[gi] <= 1'b1;
          end
          // Any other code leaves the earlier setting in force
        end
      end

      // Until written, the static setup bit chooses the edge
      assign sel_fall = edge_written_ff[gi] ? edge_fall_ff[gi] : edge_default[gi];
      // One-cycle pulse on the selected transition
      assign act_edge[gi] = changed && (sync_ff[gi][2] != sel_fall);

      // Mode register; inputs come out of reset disabled
      // Disabled by default so a stray edge before setup starts no task
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          mode_ff[gi] <= IEC_MODE_OFF;
        end else if (en_wr) begin
          case (interrupt_configure_op.code)
            CODE_DIRECT: begin
              mode_ff[gi] <= IEC_MODE_DIRECT;
            end
            CODE_DISABLE: begin
              mode_ff[gi] <= IEC_MODE_OFF;
            end
            CODE_DOWN: begin
              mode_ff[gi] <= IEC_MODE_DOWN;
            end
            CODE_UP: begin
              mode_ff[gi] <= IEC_MODE_UP;
            end
            // Codes above three are refused; the mode is kept
            default: begin
              mode_ff[gi] <= mode_ff[gi];
            end
          endcase
        end
      end

      // Counter next value and task request
      always_comb begin
        // Defaults: keep the value, ask for nothing
        nxt_pv[gi] = count_present_value_ff[gi];
        task_hit[gi] = 1'b0;
        // Operation start outranks every other change
        if (op_start) begin
          nxt_pv[gi] = PV_RESET;
        end else if (pv_wr) begin
          // Software preset of the present value
          nxt_pv[gi] = aux_req.wdata;
        end else if (en_wr && interrupt_configure_op.code == CODE_DOWN) begin
          // Enabling down mode presets from the setpoint so zero is not hit at once
          nxt_pv[gi] = count_setpoint_ff[gi];
        end else if (en_wr && interrupt_configure_op.code == CODE_UP) begin
          // Enabling up mode counts from zero
          nxt_pv[gi] = PV_RESET;
        end else if (act_edge[gi]) begin
          // An edge that meets an up or down enable write or a preset in the same cycle is lost
          case (mode_ff[gi])
            IEC_MODE_DIRECT: begin
              // Every active edge asks for the task
              task_hit[gi] = 1'b1;
            end
            IEC_MODE_UP: begin
              // Compare the next value so the wrap and the task share one edge
              if (count_present_value_ff[gi] + 16'h0001 == count_setpoint_ff[gi]) begin
                task_hit[gi] = 1'b1;
                nxt_pv[gi] = PV_RESET;
              end else begin
                // Count up by one
                nxt_pv[gi] = count_present_value_ff[gi] + 16'h0001;
              end
            end
            IEC_MODE_DOWN: begin
              // Leaving one means reaching zero; reload instead of showing zero
              // Limitation: a down count started at zero wraps to all ones
              if (count_present_value_ff[gi] == 16'h0001) begin
                task_hit[gi] = 1'b1;
                nxt_pv[gi] = count_setpoint_ff[gi];
              end else begin
                // Count down by one
                nxt_pv[gi] = count_present_value_ff[gi] - 16'h0001;
              end
            end
            default: begin
              // Disabled: edge is dropped, value kept
              nxt_pv[gi] = count_present_value_ff[gi];
            end
          endcase
        end
      end

      // Live present value
      // Trade-off: an adder per input instead of a shared one, so no arbitration
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          count_present_value_ff[gi] <= PV_RESET;
        end else begin
          count_present_value_ff[gi] <= nxt_pv[gi];
        end
      end

      // Auxiliary copy, refreshed once per controller cycle
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          aux_pv_ff[gi] <= PV_RESET;
        end else if (op_start) begin
          aux_pv_ff[gi] <= PV_RESET;
        end else if (pv_wr) begin
          // A word write shows at once, without waiting for the refresh
          aux_pv_ff[gi] <= aux_req.wdata;
        end else if (cycle_refresh) begin
          aux_pv_ff[gi] <= count_present_value_ff[gi];
        end
      end

      // Setpoint has no reset so it survives reset and operation start
      // Limitation: it reads unknown in simulation until first written
      always_ff @(posedge clk) begin
        if (sp_wr) begin
          count_setpoint_ff[gi] <= aux_req.wdata;
        end
      end
    end
  endgenerate

  // Task start pulses and the number of the lowest one firing
  // All firing inputs pulse together; the loop runs high to low so the
  // number of the lowest firing input is the one that is kept
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      task_start_ff <= '0;
      task_num_ff <= 8'h00;
    end else begin
      for (int i = NUM_IN - 1; i >= 0; i--) begin
        task_start_ff[i] <= task_hit[i];
        if (task_hit[i]) begin
          task_num_ff <= TASK_BASE + 8'(i);
        end
      end
    end
  end

  // Auxiliary word read; unmapped addresses read zero
  // Maps never overlap, so at most one address matches
  // Present-value words return the refreshed copy, not the live count
  // The answer stands one cycle after the request; the data holds after
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aux_rdata_ff <= RDATA_RESET;
      aux_rvalid_ff <= 1'b0;
    end else begin
      aux_rvalid_ff <= aux_req.rd;
      if (aux_req.rd) begin
        aux_rdata_ff <= RDATA_RESET;
        for (int i = 0; i < NUM_IN; i++) begin
          if (aux_req.addr == SP_ADDR[i]) begin
            aux_rdata_ff <= count_setpoint_ff[i];
          end
          if (aux_req.addr == PV_ADDR[i]) begin
            aux_rdata_ff <= aux_pv_ff[i];
          end
        end
      end
    end
  end

  // Direct read samples the live counter, not the refreshed copy
  // The value holds until the next direct read; done pulses one cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dread_value_ff <= RDATA_RESET;
      dread_done_ff <= 1'b0;
    end else begin
      dread_done_ff <= direct_value_read_op.valid;
      if (direct_value_read_op.valid) begin
        dread_value_ff <= count_present_value_ff[direct_value_read_op.index];
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/iec_edge_irq_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module iec_edge_irq_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire iec_pkg::iec_aux_req_type aux_req,
  input wire iec_pkg::iec_dread_type direct_value_read_op,
  input wire logic [iec_pkg::WORD_W-1:0] aux_rdata_ff,
  input wire logic aux_rvalid_ff,
  input wire logic dread_done_ff,
  input wire logic [iec_pkg::NUM_IN-1:0] task_start_ff,
  input wire logic [7:0] task_num_ff
);
  import iec_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Steps of a word read and of a task start
  sequence rd_req;
    aux_req.rd;
  endsequence
  sequence fire;
    task_start_ff != 8'h00;
  endsequence
  chk_read_answer: assert property (rd_req |=> aux_rvalid_ff)
    else $error("read not answered");
  chk_answer_cause: assert property (aux_rvalid_ff |-> $past(aux_req.rd))
    else $error("answer without read");
  chk_unmapped_zero: assert property (rd_req and aux_req.addr == 12'h300 |=> aux_rdata_ff == 16'h0000)
    else $error("unmapped read not zero");
  chk_rdata_holds: assert property (!aux_rvalid_ff |-> $stable(aux_rdata_ff))
    else $error("read data moved");
  chk_dread_answer: assert property (direct_value_read_op.valid |=> dread_done_ff)
    else $error("direct read not done");
  chk_done_cause: assert property (dread_done_ff |-> $past(direct_value_read_op.valid))
    else $error("done without request");
  chk_task_single: assert property (fire |=> (task_start_ff & $past(task_start_ff)) == 8'h00)
    else $error("task start longer than one cycle");
  chk_task_low: assert property (task_start_ff[0] |-> task_num_ff == 8'h8C)
    else $error("wrong task for input 0");
  chk_task_high: assert property (task_start_ff == 8'h80 |-> task_num_ff == 8'h93)
    else $error("wrong task for input 7");
  chk_quiet_start: assert property ($rose(reset_n) |-> (task_start_ff == 8'h00) [*3])
    else $error("task start right after reset");
endmodule
bind iec_edge_irq_counter iec_edge_irq_chk iec_edge_irq_chk_i (.clk(clk), .reset_n(reset_n),
  .aux_req(aux_req), .direct_value_read_op(direct_value_read_op), .aux_rdata_ff(aux_rdata_ff),
  .aux_rvalid_ff(aux_rvalid_ff), .dread_done_ff(dread_done_ff), .task_start_ff(task_start_ff),
  .task_num_ff(task_num_ff));
`default_nettype wire

// *** verif/iec_sensor_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Field sensors; contacts settle a few ns after the edge, away from sampling
module iec_sensor_model (
  input wire logic clk,
  input wire logic [7:0] level_cmd,
  output logic [7:0] irq_pins
);
  // Each level is held until the next command, like a real switch
  initial begin
    irq_pins = 8'h00;
    forever begin
      @(posedge clk);
      irq_pins <= #3 level_cmd;
    end
  end
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import iec_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] level_cmd = 8'h00;
  logic [7:0] irq_pins;
  logic [7:0] edge_default = 8'h02; // Input 1 falls by default
  logic op_start = 1'b0;
  logic cycle_refresh = 1'b0;
  iec_cfg_type cfg_op = '0;
  iec_aux_req_type aux_req = '0;
  iec_dread_type dread_op = '0;
  logic [15:0] aux_rdata_ff;
  logic aux_rvalid_ff;
  logic [15:0] dread_value_ff;
  logic dread_done_ff;
  logic [7:0] task_start_ff;
  logic [7:0] task_num_ff;
  logic [15:0] v;
  int mismatches = 0;
  int checks_done = 0;
  initial begin
    forever #10 clk = ~clk;
  end
  iec_sensor_model iec_sensor_model_i (.clk(clk), .level_cmd(level_cmd), .irq_pins(irq_pins));
  iec_edge_irq_counter iec_edge_irq_counter_i (.clk(clk), .reset_n(reset_n), .irq_pins(irq_pins),
    .edge_default(edge_default), .op_start(op_start), .cycle_refresh(cycle_refresh),
    .interrupt_configure_op(cfg_op), .aux_req(aux_req), .direct_value_read_op(dread_op),
    .aux_rdata_ff(aux_rdata_ff), .aux_rvalid_ff(aux_rvalid_ff), .dread_value_ff(dread_value_ff),
    .dread_done_ff(dread_done_ff), .task_start_ff(task_start_ff), .task_num_ff(task_num_ff));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Word write: one strobe cycle, no answer expected
  task automatic aux_wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk) aux_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk) aux_req <= '0;
  endtask
  // Word read: the answer is awaited under a small bound
  task automatic aux_rd(input logic [11:0] a, output logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk) aux_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk) aux_req <= '0;
    // The answer is registered at the edge that takes the request
    #1;
    while (aux_rvalid_ff !== 1'b1) begin
      n++;
      if (n > 4) begin
        mismatches++;
        finish_test();
      end
      @(posedge clk) #1;
    end
    d = aux_rdata_ff;
  endtask
  task automatic cfg(input logic [7:0] id, input logic [15:0] code);
    @(posedge clk) cfg_op <= '{valid: 1'b1, ident: id, code: code};
    @(posedge clk) cfg_op <= '0;
  endtask
  // Live value read; done and value stand from the edge that takes the request
  task automatic dread(input logic [2:0] i, input logic [15:0] exp);
    @(posedge clk) dread_op <= '{valid: 1'b1, index: i};
    @(posedge clk) dread_op <= '0;
    #1;
    cmp({15'h0000, dread_done_ff}, 16'h0001);
    cmp(dread_value_ff, exp);
  endtask
  // Sets a pin level and counts task starts; 8 cycles covers the sync delay
  task automatic pin(input int n, input logic lvl, input logic [15:0] exp);
    logic [15:0] cnt;
    cnt = 16'h0000;
    @(posedge clk) level_cmd[n] <= lvl;
    repeat (8) begin
      @(posedge clk) #1;
      if (task_start_ff[n] === 1'b1) cnt++;
    end
    cmp(cnt, exp);
  endtask
  // Hang guard well above the test's run length
  initial begin
    #1000000;
    mismatches++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++) aux_wr(SP_ADDR[i], 16'h0A00 | 16'(i));
    for (int i = 0; i < 8; i++) begin
      aux_rd(SP_ADDR[i], v);
      cmp(v, 16'h0A00 | 16'(i));
    end
    aux_rd(12'h300, v);
    cmp(v, 16'h0000);
    $display("test setpoints done");
    aux_wr(SP_ADDR[0], 16'h0003);
    cfg(8'h64, CODE_UP);
    for (int k = 0; k < 2; k++) begin
      pin(0, 1'b1, 16'h0000);
      pin(0, 1'b0, 16'h0000);
    end
    pin(0, 1'b1, 16'h0001);
    cmp({8'h00, task_num_ff}, 16'h008C);
    dread(3'h0, 16'h0000);
    $display("test up count done");
    pin(0, 1'b0, 16'h0000);
    pin(0, 1'b1, 16'h0000);
    aux_rd(PV_ADDR[0], v);
    cmp(v, 16'h0000);
    @(posedge clk) cycle_refresh <= 1'b1;
    @(posedge clk) cycle_refresh <= 1'b0;
    aux_rd(PV_ADDR[0], v);
    cmp(v, 16'h0001);
    dread(3'h0, 16'h0001);
    @(posedge clk) op_start <= 1'b1;
    @(posedge clk) op_start <= 1'b0;
    dread(3'h0, 16'h0000);
    aux_rd(PV_ADDR[0], v);
    cmp(v, 16'h0000);
    aux_rd(SP_ADDR[0], v);
    cmp(v, 16'h0003);
    $display("test refresh done");
    cfg(8'h64, CODE_DISABLE);
    pin(0, 1'b0, 16'h0000);
    pin(0, 1'b1, 16'h0000);
    dread(3'h0, 16'h0000);
    $display("test disable done");
    aux_wr(SP_ADDR[7], 16'h0002);
    cfg(8'h75, CODE_FALL);
    cfg(8'h6B, CODE_DOWN);
    pin(7, 1'b1, 16'h0000);
    dread(3'h7, 16'h0002);
    pin(7, 1'b0, 16'h0000);
    pin(7, 1'b1, 16'h0000);
    pin(7, 1'b0, 16'h0001);
    cmp({8'h00, task_num_ff}, 16'h0093);
    dread(3'h7, 16'h0002);
    $display("test down count done");
    cfg(8'h65, CODE_DIRECT);
    pin(1, 1'b1, 16'h0000);
    pin(1, 1'b0, 16'h0001);
    cfg(8'h6F, CODE_RISE);
    pin(1, 1'b1, 16'h0001);
    $display("test direct done");
    // Second reset: live counts clear, setpoints stay, word writes preset
    @(posedge clk) reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    dread(3'h7, 16'h0000);
    aux_rd(SP_ADDR[7], v);
    cmp(v, 16'h0002);
    aux_wr(PV_ADDR[2], 16'h0005);
    dread(3'h2, 16'h0005);
    aux_rd(PV_ADDR[2], v);
    cmp(v, 16'h0005);
    $display("test second reset done");
    finish_test();
  end
endmodule
`default_nettype wire
